//--- core/icr_map.svh
`ifndef ICR_MAP_SVH
`define ICR_MAP_SVH

// ****************************************************************
// Command codes.
// ****************************************************************
`define ICR_CMD_NV_WRITE_ENABLE 8'h06
`define ICR_CMD_V_WRITE_ENABLE 8'h50
`define ICR_CMD_REGISTER_WRITE 8'h01
`define ICR_CMD_ANY_REGISTER_WRITE 8'h71
`define ICR_CMD_ANY_REGISTER_READ 8'h65
`define ICR_CMD_STATUS_READ 8'h05
`define ICR_CMD_ENTER_WIDE 8'h38
`define ICR_CMD_EXIT_WIDE 8'hf5
`define ICR_CMD_SOFT_RESET 8'h99

// ****************************************************************
// Register addresses for the any-register commands.
// ****************************************************************
`define ICR_ADDR_STATUS_LIVE 24'h000000
`define ICR_ADDR_WIDTH_LIVE 24'h800002
`define ICR_ADDR_IFC_NV 24'h000003
`define ICR_ADDR_IFC_LIVE 24'h800003

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define ICR_BIT_RESET_PIN 7
`define ICR_BIT_DRIVE_HI 6
`define ICR_BIT_DRIVE_LO 5
`define ICR_BIT_WIDE 3
`define ICR_BIT_PROTECT 2
`define ICR_BIT_ADDR_DEFAULT 1
`define ICR_BIT_ADDR_CURRENT 0
`define ICR_BIT_QUAD 1
`define ICR_BIT_BUSY 0
`define ICR_BIT_WEL 1
`define ICR_NV_RESET 8'h60
`define ICR_NV_WRITE_MASK 8'hee
`define ICR_LIVE_WRITE_MASK 8'hed
`define ICR_QUAD_RESET 1'b0

// ****************************************************************
// Timing.
// ****************************************************************
`define ICR_CORE_CLK_MHZ 100
`define ICR_NV_PROG_TIME_US 100
`define ICR_NV_PROG_CYCLES (`ICR_NV_PROG_TIME_US * `ICR_CORE_CLK_MHZ)

`endif

//--- core/icr_pkg.sv
`default_nettype none
package icr_pkg;

  typedef enum logic [5:0] {
    ICR_IDLE = 6'b000001,
    ICR_ADDR = 6'b000010,
    ICR_DUMMY = 6'b000100,
    ICR_RDATA = 6'b001000,
    ICR_WDATA = 6'b010000,
    ICR_SKIP = 6'b100000
  } icr_phase_e;

  typedef enum logic [1:0] {
    ICR_TGT_NONE = 2'h0,
    ICR_TGT_NV = 2'h1,
    ICR_TGT_LIVE = 2'h2,
    ICR_TGT_WIDTH = 2'h3
  } icr_target_e;

  typedef struct packed {
    logic reset_pin_enable;
    logic [1:0] drive_strength;
    logic wide_instruction;
    logic quad_data_width;
    logic wp_as_io2;
    logic individual_lock;
    logic addr_4byte;
    logic busy;
  } icr_ctl_s;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_prev;
    logic io3_s1;
    logic io3_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_prev;
    icr_phase_e phase;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [2:0] addr_cnt;
    logic [1:0] data_idx;
    icr_target_e pend_tgt;
    logic [7:0] pend_data;
    logic pend_w_valid;
    logic [7:0] pend_w_data;
    logic [7:0] nv;
    logic [7:0] live;
    logic quad;
    logic wel_nv;
    logic wel_v;
    logic busy;
    logic [31:0] prog_cnt;
    logic [7:0] prog_data;
    logic [7:0] tx_byte;
    logic tx_en;
    logic link_wide;
    icr_ctl_s ctl;
  } icr_core_s;

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] rx_byte;
    logic rx_tog;
  } icr_link_s;

  typedef struct packed {
    logic [7:0] shreg;
    logic [3:0] io_out;
    logic [3:0] io_oe_n;
  } icr_tx_s;

endpackage
`default_nettype wire

//--- core/icr_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "icr_map.svh"

module icr_top #(
  parameter int unsigned NV_PROG_CYCLES = `ICR_NV_PROG_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE_N,
  output icr_pkg::icr_ctl_s CTRL
);
  import icr_pkg::*;

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  function automatic logic [7:0] live_from_nv(input logic [7:0] nv);
    logic [7:0] v;
    v = nv & `ICR_NV_WRITE_MASK;
    v[`ICR_BIT_ADDR_CURRENT] = nv[`ICR_BIT_ADDR_DEFAULT];
    return v;
  endfunction

  function automatic icr_ctl_s ctl_of(input logic [7:0] live, input logic quad,
                                      input logic busy);
    icr_ctl_s c;
    c.reset_pin_enable = live[`ICR_BIT_RESET_PIN];
    c.drive_strength = live[`ICR_BIT_DRIVE_HI:`ICR_BIT_DRIVE_LO];
    c.wide_instruction = live[`ICR_BIT_WIDE];
    c.quad_data_width = quad | live[`ICR_BIT_WIDE];
    c.wp_as_io2 = quad | live[`ICR_BIT_WIDE];
    c.individual_lock = live[`ICR_BIT_PROTECT];
    c.addr_4byte = live[`ICR_BIT_ADDR_CURRENT];
    c.busy = busy;
    return c;
  endfunction

  function automatic icr_target_e target_of(input logic [23:0] a, input logic wel_nv,
                                            input logic wel_v);
    icr_target_e t;
    t = ICR_TGT_NONE;
    if (a == `ICR_ADDR_IFC_NV && wel_nv) begin
      t = ICR_TGT_NV;
    end else if (a == `ICR_ADDR_IFC_LIVE && (wel_nv || wel_v)) begin
      t = ICR_TGT_LIVE;
    end else if (a == `ICR_ADDR_WIDTH_LIVE && (wel_nv || wel_v)) begin
      t = ICR_TGT_WIDTH;
    end
    return t;
  endfunction

  // ****************************************************************
  // State.
  // ****************************************************************
  icr_core_s core;
  icr_core_s next_core;
  icr_link_s link;
  icr_link_s next_link;
  icr_tx_s tx;
  icr_tx_s next_tx;
  localparam icr_tx_s TX_IDLE = '{shreg: 8'h00, io_out: 4'h0, io_oe_n: 4'hf};

  logic frame_start;
  logic frame_end;
  logic byte_evt;
  logic hw_reset;
  logic soft_reset;
  logic link_done;
  logic [2:0] addr_last;
  logic [7:0] status_byte;
  logic [7:0] rx;

  // ****************************************************************
  // Core domain: command decode, registers and programming.
  // ****************************************************************
  always_comb begin
    next_core = core;
    soft_reset = 1'b0;
    rx = link.rx_byte;
    next_core.cs_s1 = CS_N;
    next_core.cs_s2 = core.cs_s1;
    next_core.cs_prev = core.cs_s2;
    next_core.io3_s1 = IO_IN[3];
    next_core.io3_s2 = core.io3_s1;
    next_core.tog_s1 = link.rx_tog;
    next_core.tog_s2 = core.tog_s1;
    next_core.tog_prev = core.tog_s2;
    frame_start = core.cs_prev & ~core.cs_s2;
    frame_end = ~core.cs_prev & core.cs_s2;
    byte_evt = (core.tog_s2 != core.tog_prev) & ~core.cs_s2;
    addr_last = core.live[`ICR_BIT_ADDR_CURRENT] ? 3'd3 : 3'd2;
    status_byte = {6'h00, core.wel_nv | core.wel_v, core.busy};
    // Quad width counts as on while the wide protocol is on.
    hw_reset = core.live[`ICR_BIT_RESET_PIN] & ~core.io3_s2 &
               (core.cs_s2 | ~(core.quad | core.live[`ICR_BIT_WIDE]) |
                ~core.live[`ICR_BIT_WIDE]);
    if (frame_start) begin
      next_core.phase = ICR_IDLE;
      next_core.opcode = 8'h00;
      next_core.pend_tgt = ICR_TGT_NONE;
      next_core.pend_w_valid = 1'b0;
      next_core.tx_en = 1'b0;
    end
    if (byte_evt) begin
      unique case (core.phase)
        ICR_IDLE: begin
          next_core.opcode = rx;
          next_core.addr_cnt = 3'd0;
          next_core.data_idx = 2'd0;
          if (core.busy && rx != `ICR_CMD_STATUS_READ && rx != `ICR_CMD_ANY_REGISTER_READ) begin
            next_core.opcode = 8'h00;
            next_core.phase = ICR_SKIP;
          end else if (rx == `ICR_CMD_STATUS_READ) begin
            next_core.phase = ICR_DUMMY;
            next_core.tx_byte = status_byte;
            next_core.tx_en = 1'b1;
          end else if (rx == `ICR_CMD_ANY_REGISTER_READ || rx == `ICR_CMD_ANY_REGISTER_WRITE) begin
            next_core.phase = ICR_ADDR;
          end else if (rx == `ICR_CMD_REGISTER_WRITE) begin
            next_core.phase = ICR_WDATA;
          end else begin
            next_core.phase = ICR_SKIP;
          end
        end
        ICR_ADDR: begin
          next_core.addr = {core.addr[23:0], rx};
          next_core.addr_cnt = 3'(core.addr_cnt + 3'd1);
          if (core.addr_cnt == addr_last) begin
            if (core.opcode == `ICR_CMD_ANY_REGISTER_READ) begin
              next_core.phase = ICR_DUMMY;
              next_core.tx_en = 1'b1;
              unique case (next_core.addr[23:0])
                `ICR_ADDR_STATUS_LIVE: next_core.tx_byte = status_byte;
                `ICR_ADDR_WIDTH_LIVE: next_core.tx_byte = {6'h00, core.quad, 1'b0};
                `ICR_ADDR_IFC_NV: next_core.tx_byte = core.nv;
                `ICR_ADDR_IFC_LIVE: next_core.tx_byte = core.live;
                default: next_core.tx_byte = 8'h00;
              endcase
            end else begin
              next_core.phase = ICR_WDATA;
            end
          end
        end
        ICR_DUMMY: begin
          next_core.phase = ICR_RDATA;
        end
        ICR_RDATA: begin
          if (core.opcode == `ICR_CMD_STATUS_READ) begin
            next_core.tx_byte = status_byte;
          end
        end
        ICR_WDATA: begin
          next_core.data_idx = (core.data_idx == 2'd3) ? 2'd3 : 2'(core.data_idx + 2'd1);
          if (core.opcode == `ICR_CMD_REGISTER_WRITE) begin
            if (core.data_idx == 2'd1) begin
              next_core.pend_w_valid = core.wel_nv | core.wel_v;
              next_core.pend_w_data = rx;
            end else if (core.data_idx == 2'd2) begin
              next_core.pend_data = rx;
              next_core.pend_tgt = core.wel_nv ? ICR_TGT_NV :
                                   (core.wel_v ? ICR_TGT_LIVE : ICR_TGT_NONE);
            end
          end else if (core.data_idx == 2'd0) begin
            next_core.pend_data = rx;
            next_core.pend_tgt = target_of(core.addr[23:0], core.wel_nv, core.wel_v);
          end
        end
        ICR_SKIP: begin
        end
        default: next_core.phase = ICR_SKIP;
      endcase
    end
    if (frame_end) begin
      next_core.tx_en = 1'b0;
      next_core.phase = ICR_SKIP;
      unique case (core.opcode)
        `ICR_CMD_NV_WRITE_ENABLE: next_core.wel_nv = 1'b1;
        `ICR_CMD_V_WRITE_ENABLE: next_core.wel_v = 1'b1;
        `ICR_CMD_ENTER_WIDE: next_core.live[`ICR_BIT_WIDE] = 1'b1;
        `ICR_CMD_EXIT_WIDE: next_core.live[`ICR_BIT_WIDE] = 1'b0;
        `ICR_CMD_SOFT_RESET: soft_reset = 1'b1;
        `ICR_CMD_REGISTER_WRITE, `ICR_CMD_ANY_REGISTER_WRITE: begin
          if (core.pend_w_valid) begin
            next_core.quad = core.pend_w_data[`ICR_BIT_QUAD];
          end
          next_core.wel_v = 1'b0;
          if (core.pend_tgt != ICR_TGT_NV) begin
            next_core.wel_nv = 1'b0;
          end
          unique case (core.pend_tgt)
            ICR_TGT_NV: begin
              next_core.busy = 1'b1;
              next_core.prog_cnt = 32'(NV_PROG_CYCLES - 1);
              next_core.prog_data = core.pend_data & `ICR_NV_WRITE_MASK;
            end
            ICR_TGT_LIVE: begin
              next_core.live = (core.pend_data & `ICR_LIVE_WRITE_MASK) |
                               (core.live & ~`ICR_LIVE_WRITE_MASK);
            end
            ICR_TGT_WIDTH: next_core.quad = core.pend_data[`ICR_BIT_QUAD];
            ICR_TGT_NONE: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end
    if (core.busy) begin
      if (core.prog_cnt == 32'd0) begin
        next_core.nv = core.prog_data;
        next_core.live[`ICR_BIT_ADDR_DEFAULT] = core.prog_data[`ICR_BIT_ADDR_DEFAULT];
        next_core.live[`ICR_BIT_ADDR_CURRENT] = core.prog_data[`ICR_BIT_ADDR_DEFAULT];
        next_core.busy = 1'b0;
        next_core.wel_nv = 1'b0;
      end else begin
        next_core.prog_cnt = 32'(core.prog_cnt - 32'd1);
      end
    end
    if (hw_reset || soft_reset) begin
      next_core.live = live_from_nv(next_core.nv);
      next_core.quad = `ICR_QUAD_RESET;
      next_core.wel_v = 1'b0;
      if (!core.busy) begin
        next_core.wel_nv = 1'b0;
      end
      next_core.opcode = 8'h00;
      next_core.phase = ICR_SKIP;
      next_core.tx_en = 1'b0;
    end
    if (next_core.cs_s2) begin
      next_core.link_wide = next_core.live[`ICR_BIT_WIDE];
    end
    next_core.ctl = ctl_of(next_core.live, next_core.quad, next_core.busy);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      core <= '0;
      core.cs_s1 <= 1'b1;
      core.cs_s2 <= 1'b1;
      core.cs_prev <= 1'b1;
      core.io3_s1 <= 1'b1;
      core.io3_s2 <= 1'b1;
      core.phase <= ICR_SKIP;
      core.nv <= `ICR_NV_RESET;
      core.live <= live_from_nv(`ICR_NV_RESET);
      core.quad <= `ICR_QUAD_RESET;
      core.ctl <= ctl_of(live_from_nv(`ICR_NV_RESET), `ICR_QUAD_RESET, 1'b0);
    end else begin
      core <= next_core;
    end
  end

  // ****************************************************************
  // Link domain: input shifting on the rising serial clock.
  // ****************************************************************
  always_comb begin
    next_link = link;
    if (core.link_wide) begin
      next_link.shreg = {link.shreg[3:0], IO_IN};
      link_done = (link.bit_cnt == 3'd4);
      next_link.bit_cnt = link_done ? 3'd0 : 3'd4;
    end else begin
      next_link.shreg = {link.shreg[6:0], IO_IN[0]};
      link_done = (link.bit_cnt == 3'd7);
      next_link.bit_cnt = 3'(link.bit_cnt + 3'd1);
    end
    if (link_done) begin
      next_link.rx_byte = next_link.shreg;
      next_link.rx_tog = ~link.rx_tog;
    end
  end

  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // ****************************************************************
  // Link domain: output shifting on the falling serial clock.
  // ****************************************************************
  always_comb begin
    next_tx = tx;
    if (link.bit_cnt == 3'd0) begin
      if (core.tx_en && core.link_wide) begin
        next_tx.io_out = core.tx_byte[7:4];
        next_tx.shreg = {core.tx_byte[3:0], 4'h0};
        next_tx.io_oe_n = 4'h0;
      end else if (core.tx_en) begin
        next_tx.io_out = {2'b00, core.tx_byte[7], 1'b0};
        next_tx.shreg = {core.tx_byte[6:0], 1'b0};
        next_tx.io_oe_n = 4'hd;
      end else begin
        next_tx = TX_IDLE;
      end
    end else if (core.link_wide) begin
      next_tx.io_out = tx.shreg[7:4];
      next_tx.shreg = {tx.shreg[3:0], 4'h0};
    end else begin
      next_tx.io_out = {2'b00, tx.shreg[7], 1'b0};
      next_tx.shreg = {tx.shreg[6:0], 1'b0};
    end
  end

  always_ff @(negedge SCK or posedge CS_N) begin
    if (CS_N) begin
      tx <= TX_IDLE;
    end else begin
      tx <= next_tx;
    end
  end

  assign IO_OUT = tx.io_out;
  assign IO_OE_N = tx.io_oe_n;
  assign CTRL = core.ctl;

endmodule // icr_top
`default_nettype wire

//--- verification/icr_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module icr_top_monitor #(
  parameter int unsigned NV_PROG_CYCLES = 20
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic [3:0] IO_IN,
  input wire logic [3:0] IO_OUT,
  input wire logic [3:0] IO_OE_N,
  input wire icr_pkg::icr_ctl_s CTRL
);
  import icr_pkg::*;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  logic [31:0] busy_cnt;

  // Counts the cycles for which the busy indication has stood.
  always_ff @(posedge CORE_CLK) begin
    if (RST || !CTRL.busy) begin
      busy_cnt <= 32'h0;
    end else begin
      busy_cnt <= busy_cnt + 32'h1;
    end
  end

  property p_reset_load;
    $fell(RST) |-> CTRL == 9'h0c0;
  endproperty
  property p_quad_pair;
    CTRL.quad_data_width == CTRL.wp_as_io2;
  endproperty
  property p_wide_quad;
    CTRL.wide_instruction |-> CTRL.quad_data_width;
  endproperty
  property p_idle_release;
    CS_N [*2] |-> IO_OE_N == 4'hf;
  endproperty
  property p_wide_drive;
    IO_OE_N == 4'h0 |-> CTRL.wide_instruction;
  endproperty
  property p_serial_drive;
    IO_OE_N == 4'hd |-> !CTRL.wide_instruction;
  endproperty
  property p_busy_len;
    $fell(CTRL.busy) |-> busy_cnt == NV_PROG_CYCLES;
  endproperty
  property p_busy_start;
    $rose(CTRL.busy) |-> CS_N && $past(CS_N);
  endproperty
  property p_frame_stable;
    (!CS_N) [*8] |-> $stable(CTRL.wide_instruction) && $stable(CTRL.drive_strength);
  endproperty

  a_reset_load: assert property (p_reset_load) else $error("controls not at defaults");
  a_quad_pair: assert property (p_quad_pair) else $error("quad and io2 differ");
  a_wide_quad: assert property (p_wide_quad) else $error("wide without quad");
  a_idle_release: assert property (p_idle_release) else $error("lines driven while idle");
  a_wide_drive: assert property (p_wide_drive) else $error("four lines driven in serial");
  a_serial_drive: assert property (p_serial_drive) else $error("one line driven in wide");
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  a_busy_start: assert property (p_busy_start) else $error("busy rose inside a frame");
  a_frame_stable: assert property (p_frame_stable) else $error("mode changed in a frame");

endmodule // icr_top_monitor

bind icr_top icr_top_monitor #(.NV_PROG_CYCLES(NV_PROG_CYCLES)) mon_u (
  .CORE_CLK(CORE_CLK),
  .RST(RST),
  .SCK(SCK),
  .CS_N(CS_N),
  .IO_IN(IO_IN),
  .IO_OUT(IO_OUT),
  .IO_OE_N(IO_OE_N),
  .CTRL(CTRL)
);

`default_nettype wire

//--- verification/icr_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module icr_host_model (
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n
);
  logic wide;
  logic [3:0] drv;
  logic [3:0] dout;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    wide = 1'b0;
    drv = 4'hd;
    dout = 4'hd;
  end

  // A released line shows the inverse of the host's last value.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_in[i] = !io_oe_n[i] ? io_out[i] : (drv[i] ? dout[i] : !dout[i]);
    end
  end

  task automatic put(input logic [7:0] b);
    for (int k = 0; k < (wide ? 2 : 8); k++) begin
      if (wide) begin
        dout = b[7 - 4 * k -: 4];
      end else begin
        dout[0] = b[7 - k];
      end
      #16 sck = 1'b1;
      #16 sck = 1'b0;
    end
  endtask

  task automatic get(output logic [7:0] b);
    b = 8'h00;
    drv = wide ? 4'h0 : 4'hd;
    for (int k = 0; k < (wide ? 2 : 8); k++) begin
      #16 sck = 1'b1;
      b = wide ? {b[3:0], io_in} : {b[6:0], io_in[1]};
      #16 sck = 1'b0;
    end
  endtask

  task automatic frame(input logic [7:0] op, input int na, input logic [31:0] ad, input int nw,
                       input logic [23:0] wd, input logic rd, output logic [7:0] rb);
    rb = 8'h00;
    drv = wide ? 4'hf : 4'hd;
    cs_n = 1'b0;
    #16;
    put(op);
    for (int i = na - 1; i >= 0; i--) begin
      put(ad[8 * i +: 8]);
    end
    for (int i = nw - 1; i >= 0; i--) begin
      put(wd[8 * i +: 8]);
    end
    if (rd) begin
      put(8'h00);
      get(rb);
    end
    #16 cs_n = 1'b1;
    drv = 4'hd;
    dout = 4'hd;
    #100;
  endtask

endmodule // icr_host_model

`default_nettype wire

//--- verification/tb_nv_interface_default_config.sv
`timescale 1ns/10ps
`default_nettype none
`include "icr_map.svh"

module tb_nv_interface_default_config;
  import icr_pkg::*;

  localparam int unsigned PROG = 200;
  localparam logic [31:0] NV_A = {8'h00, `ICR_ADDR_IFC_NV};
  localparam logic [31:0] LV_A = {8'h00, `ICR_ADDR_IFC_LIVE};

  logic core_clk;
  logic rst;
  wire sck;
  wire cs_n;
  wire [3:0] io_in;
  logic [3:0] io_out;
  logic [3:0] io_oe_n;
  icr_ctl_s ctrl;
  int err_total;
  int check_count;
  int alen;
  logic [7:0] rb;

  icr_top #(.NV_PROG_CYCLES(PROG)) dut_u (.CORE_CLK(core_clk), .RST(rst), .SCK(sck),
    .CS_N(cs_n), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE_N(io_oe_n), .CTRL(ctrl));
  icr_host_model host_u (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe_n(io_oe_n));

  initial begin
    core_clk = 1'b0;
  end
  always #5 core_clk = ~core_clk;

  function automatic icr_ctl_s ctl(input logic [7:0] v, input logic q, input logic b);
    ctl = {v[7], v[6:5], v[3], q | v[3], q | v[3], v[2], v[0], b};
  endfunction

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkc(input icr_ctl_s exp);
    @(posedge core_clk);
    #1;
    chk(ctrl, exp);
  endtask

  task automatic cmd(input logic [7:0] op);
    host_u.frame(op, 0, 32'h0, 0, 24'h0, 1'b0, rb);
  endtask

  task automatic sts;
    host_u.frame(8'h05, 0, 32'h0, 0, 24'h0, 1'b1, rb);
  endtask

  task automatic wr_live(input logic [7:0] d);
    cmd(8'h50);
    host_u.frame(8'h71, alen, LV_A, 1, {16'h0, d}, 1'b0, rb);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [7:0] e);
    host_u.frame(8'h65, alen, a, 0, 24'h0, 1'b1, rb);
    chk({1'b0, rb}, {1'b0, e});
  endtask

  task automatic pulse;
    host_u.dout[3] = 1'b0;
    repeat (20) @(posedge core_clk);
    #1 host_u.dout[3] = 1'b1;
    repeat (5) @(posedge core_clk);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ********************************************************************
  // Test sequence.
  // ********************************************************************
  initial begin
    rst = 1'b1;
    err_total = 0;
    check_count = 0;
    alen = 3;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    chkc(ctl(8'h60, 1'b0, 1'b0));
    rd_chk(NV_A, 8'h60);
    rd_chk(LV_A, 8'h60);
    wr_live(8'h00);
    pulse();
    chkc(ctl(8'h00, 1'b0, 1'b0));
    for (int d = 0; d < 4; d++) begin
      wr_live({1'b0, d[1:0], 2'b00, d[0], 2'b00});
      chkc(ctl({1'b0, d[1:0], 2'b00, d[0], 2'b00}, 1'b0, 1'b0));
    end
    cmd(8'h50);
    host_u.frame(8'h01, 0, 32'h0, 3, 24'h000208, 1'b0, rb);
    host_u.wide = 1'b1;
    chkc(ctl(8'h08, 1'b1, 1'b0));
    rd_chk(LV_A, 8'h08);
    rd_chk({8'h00, `ICR_ADDR_WIDTH_LIVE}, 8'h02);
    cmd(8'hf5);
    host_u.wide = 1'b0;
    chkc(ctl(8'h00, 1'b1, 1'b0));
    cmd(8'h38);
    host_u.wide = 1'b1;
    chkc(ctl(8'h08, 1'b1, 1'b0));
    wr_live(8'h00);
    host_u.wide = 1'b0;
    chkc(ctl(8'h00, 1'b1, 1'b0));
    host_u.frame(8'h71, 3, NV_A, 1, 24'h0000ff, 1'b0, rb);
    chkc(ctl(8'h00, 1'b1, 1'b0));
    rd_chk(NV_A, 8'h60);
    cmd(8'h06);
    host_u.frame(8'h71, 3, NV_A, 1, 24'h0000ff, 1'b0, rb);
    chkc(ctl(8'h00, 1'b1, 1'b1));
    sts();
    chk({1'b0, rb}, 9'h003);
    for (int n = 0; n < 50 && rb[0] !== 1'b0; n++) begin
      sts();
    end
    chk({1'b0, rb}, 9'h000);
    chkc(ctl(8'h03, 1'b1, 1'b0));
    alen = 4;
    rd_chk(NV_A, 8'hee);
    cmd(8'h99);
    host_u.wide = 1'b1;
    chkc(ctl(8'hef, 1'b0, 1'b0));
    wr_live(8'h8f);
    chkc(ctl(8'h8f, 1'b0, 1'b0));
    pulse();
    chkc(ctl(8'hef, 1'b0, 1'b0));
    give_verdict();
  end

  initial begin
    #500000;
    err_total++;
    give_verdict();
  end

endmodule // tb_nv_interface_default_config

`default_nettype wire
